// ==== hdl/patarm_map.svh ====
// register map, field positions and reset values of the pattern arm block
//
// How it works
// - an 8-bit output-state register holds one bit per trigger-bus line
// - an output line other than the arm event line is driven high or low after its output-state bit
// - the output-state bit of a line set to input has no effect
// - pattern arm mode takes bus lines, digital io, timer and software arm
// - software arm is always honoured in pattern arm mode, with no enable
// - an arm event needs every configured condition at once, combined by AND
// - several conditions on one line are combined by OR for that line
// - bus conditions are four 8-bit masks, bit n for bus line n
// - digital io conditions are four 16-bit masks, bit n for io line n
// - bus mask 0 rising edge, 2 high level, 3 low level
// - mask 1 is falling edge for bus and digital io lines
// - io mask 0 rising edge, 2 high level, 3 low level
// - timer enable set gives periodic arm events, clear gives none
// - the combined arm event is driven on one selectable bus line
// - the own arm is taken from a separately selectable bus line
// - output lines drive the internal bus always, external only in wide scope
// - input lines read external bus in wide scope, otherwise internal bus
`ifndef PATARM_MAP_SVH
`define PATARM_MAP_SVH

// -------------------------------------------------------------------------
// byte offsets on the register bus
// -------------------------------------------------------------------------
`define PATARM_OFS_CTRL     8'h00
`define PATARM_OFS_DIR      8'h04
`define PATARM_OFS_SCOPE    8'h08
`define PATARM_OFS_OUTSTATE 8'h0c
`define PATARM_OFS_BUSMASK0 8'h10
`define PATARM_OFS_IOMASK0  8'h20
`define PATARM_OFS_PERIOD   8'h30
`define PATARM_OFS_SWARM    8'h34
`define PATARM_OFS_STATUS   8'h38
`define PATARM_MASK_STRIDE  8'h04

// -------------------------------------------------------------------------
// fields of the control word, the software arm word and the status word
// -------------------------------------------------------------------------
`define PATARM_CTRL_MODE    0
`define PATARM_CTRL_TIMER   1
`define PATARM_CTRL_OSEL    6:4
`define PATARM_CTRL_ISEL    10:8
`define PATARM_SWARM_BIT    0
`define PATARM_STAT_BUS     7:0
`define PATARM_STAT_IO      23:8
`define PATARM_STAT_EVENT   24

// -------------------------------------------------------------------------
// reset values and timer counter constants
// -------------------------------------------------------------------------
`define PATARM_RST_BYTE     8'h00
`define PATARM_RST_WORD     16'h0000
`define PATARM_RST_SEL      3'h0
`define PATARM_RST_PERIOD   32'h0000_07cf
`define PATARM_RST_DATA     32'h0000_0000
`define PATARM_COUNT_ZERO   32'h0000_0000
`define PATARM_COUNT_ONE    32'h0000_0001

`endif

// ==== hdl/patarm_pkg.sv ====
// types shared by the pattern arm block
`default_nettype none
package patarm_pkg;
  // bus slave handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } patarm_bus_e;

  typedef logic [7:0]  patarm_bus_t;
  typedef logic [15:0] patarm_io_t;
  typedef logic [2:0]  patarm_sel_t;
endpackage
`default_nettype wire

// ==== hdl/patarm_line_qual.sv ====
// per-line input conditioning and condition match for one group of lines
`timescale 1ns/1ps
`default_nettype none
module patarm_line_qual #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] raw_in,
  input  wire logic [W-1:0] mask_rise,
  input  wire logic [W-1:0] mask_fall,
  input  wire logic [W-1:0] mask_high,
  input  wire logic [W-1:0] mask_low,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic              all_ok,
  output logic              any_cfg
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;
  logic [W-1:0] line_ok;
  logic [W-1:0] line_cfg;

  // two-flop synchroniser and previous sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;

  // per line: any enabled condition satisfies it, unconfigured lines pass
  genvar n;
  generate
    for (n = 0; n < W; n++) begin : g_line
      logic fall_n;
      assign fall_n = ~sync_q[n] & last_q[n];
      assign line_cfg[n] = mask_rise[n] | mask_fall[n] | mask_high[n] | mask_low[n];
      assign line_ok[n]  = ~line_cfg[n]
                         | (mask_rise[n] & rise[n])
                         | (mask_fall[n] & fall_n)
                         | (mask_high[n] & sync_q[n])
                         | (mask_low[n]  & ~sync_q[n]);
    end
  endgenerate

  assign all_ok  = &line_ok;
  assign any_cfg = |line_cfg;
endmodule
`default_nettype wire

// ==== hdl/patarm_top.sv ====
// pattern arm event logic and trigger-bus output state with avalon registers
`timescale 1ns/1ps
`default_nettype none
`include "patarm_map.svh"
module patarm_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [7:0]  EXT_BUS_IN,
  output logic      [7:0]  EXT_BUS_OUT,
  output logic      [7:0]  EXT_BUS_OE_N,
  input  wire logic [7:0]  INT_BUS_IN,
  output logic      [7:0]  INT_BUS_OUT,
  output logic      [7:0]  INT_BUS_DRIVE,
  input  wire logic [15:0] DIGITAL_IO_IN,
  output logic             ARM_EVENT,
  output logic             ARM_OUT
);
  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  patarm_pkg::patarm_bus_e state_q;
  patarm_pkg::patarm_bus_t dir_q;
  patarm_pkg::patarm_bus_t scope_q;
  patarm_pkg::patarm_bus_t out_state_q;
  patarm_pkg::patarm_bus_t bus_mask_q [4];
  patarm_pkg::patarm_io_t  io_mask_q  [4];
  patarm_pkg::patarm_sel_t out_sel_q;
  patarm_pkg::patarm_sel_t in_sel_q;
  logic                    mode_q;
  logic                    timer_en_q;
  logic [31:0]             period_q;
  logic [31:0]             count_q;
  logic                    tick_q;
  logic                    sw_arm_q;
  logic                    event_d;
  logic [31:0]             rdata_d;
  logic                    wr_fire;
  logic [7:0]              bus_raw;
  logic [7:0]              bus_level;
  logic [7:0]              bus_rise;
  logic [15:0]             io_level;
  logic                    bus_ok;
  logic                    bus_cfg;
  logic                    io_ok;
  logic                    io_cfg;
  logic [7:0]              out_hot;
  logic [7:0]              drive_v;

  // byte-lane merge of a write into an existing register value
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // one-hot select of a bus line
  function automatic logic [7:0] line_hot(input logic [2:0] sel);
    logic [7:0] res;
    res = 8'h00;
    res[sel] = 1'b1;
    return res;
  endfunction

  // -----------------------------------------------------------------------
  // avalon slave: one wait cycle, write commits at the released edge
  // -----------------------------------------------------------------------
  assign wr_fire = (state_q == patarm_pkg::BUS_ACK) && AVS_WRITE;

  // handshake sequencer; waitrequest sits high except in the answer cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_q         <= patarm_pkg::BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      case (state_q)
        patarm_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            state_q         <= patarm_pkg::BUS_ACK;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        patarm_pkg::BUS_ACK: begin
          state_q         <= patarm_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          state_q         <= patarm_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdata_d = `PATARM_RST_DATA;
    if (AVS_ADDRESS == `PATARM_OFS_CTRL) begin
      rdata_d[`PATARM_CTRL_MODE]  = mode_q;
      rdata_d[`PATARM_CTRL_TIMER] = timer_en_q;
      rdata_d[`PATARM_CTRL_OSEL]  = out_sel_q;
      rdata_d[`PATARM_CTRL_ISEL]  = in_sel_q;
    end else if (AVS_ADDRESS == `PATARM_OFS_DIR) begin
      rdata_d[7:0] = dir_q;
    end else if (AVS_ADDRESS == `PATARM_OFS_SCOPE) begin
      rdata_d[7:0] = scope_q;
    end else if (AVS_ADDRESS == `PATARM_OFS_OUTSTATE) begin
      rdata_d[7:0] = out_state_q;
    end else if (AVS_ADDRESS == `PATARM_OFS_PERIOD) begin
      rdata_d = period_q;
    end else if (AVS_ADDRESS == `PATARM_OFS_STATUS) begin
      rdata_d[`PATARM_STAT_BUS]   = bus_level;
      rdata_d[`PATARM_STAT_IO]    = io_level;
      rdata_d[`PATARM_STAT_EVENT] = ARM_EVENT;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (AVS_ADDRESS == `PATARM_OFS_BUSMASK0 + 8'(k) * `PATARM_MASK_STRIDE) begin
          rdata_d[7:0] = bus_mask_q[k];
        end
        if (AVS_ADDRESS == `PATARM_OFS_IOMASK0 + 8'(k) * `PATARM_MASK_STRIDE) begin
          rdata_d[15:0] = io_mask_q[k];
        end
      end
    end
  end

  // read data is captured on the taking edge and stands through the answer
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      AVS_READDATA <= `PATARM_RST_DATA;
    end else if (state_q == patarm_pkg::BUS_IDLE && AVS_READ) begin
      AVS_READDATA <= rdata_d;
    end
  end

  // -----------------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------------
  // control word and line configuration
  always_ff @(posedge CLOCK) begin
    logic [31:0] m;
    m = `PATARM_RST_DATA;
    if (!RST_N) begin
      mode_q      <= 1'b0;
      timer_en_q  <= 1'b0;
      out_sel_q   <= `PATARM_RST_SEL;
      in_sel_q    <= `PATARM_RST_SEL;
      dir_q       <= `PATARM_RST_BYTE;
      scope_q     <= `PATARM_RST_BYTE;
      out_state_q <= `PATARM_RST_BYTE;
      period_q    <= `PATARM_RST_PERIOD;
    end else if (wr_fire) begin
      if (AVS_ADDRESS == `PATARM_OFS_CTRL) begin
        m = be_merge({21'h000000, in_sel_q, 1'b0, out_sel_q, 2'h0, timer_en_q, mode_q},
                     AVS_WRITEDATA, AVS_BYTEENABLE);
        mode_q     <= m[`PATARM_CTRL_MODE];
        timer_en_q <= m[`PATARM_CTRL_TIMER];
        out_sel_q  <= m[`PATARM_CTRL_OSEL];
        in_sel_q   <= m[`PATARM_CTRL_ISEL];
      end else if (AVS_ADDRESS == `PATARM_OFS_DIR) begin
        m = be_merge({24'h000000, dir_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
        dir_q <= m[7:0];
      end else if (AVS_ADDRESS == `PATARM_OFS_SCOPE) begin
        m = be_merge({24'h000000, scope_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
        scope_q <= m[7:0];
      end else if (AVS_ADDRESS == `PATARM_OFS_OUTSTATE) begin
        m = be_merge({24'h000000, out_state_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
        out_state_q <= m[7:0];
      end else if (AVS_ADDRESS == `PATARM_OFS_PERIOD) begin
        period_q <= be_merge(period_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  // condition masks, one word per condition type and line group
  always_ff @(posedge CLOCK) begin
    logic [31:0] m;
    m = `PATARM_RST_DATA;
    if (!RST_N) begin
      for (int k = 0; k < 4; k++) begin
        bus_mask_q[k] <= `PATARM_RST_BYTE;
        io_mask_q[k]  <= `PATARM_RST_WORD;
      end
    end else if (wr_fire) begin
      for (int k = 0; k < 4; k++) begin
        if (AVS_ADDRESS == `PATARM_OFS_BUSMASK0 + 8'(k) * `PATARM_MASK_STRIDE) begin
          m = be_merge({24'h000000, bus_mask_q[k]}, AVS_WRITEDATA, AVS_BYTEENABLE);
          bus_mask_q[k] <= m[7:0];
        end
        if (AVS_ADDRESS == `PATARM_OFS_IOMASK0 + 8'(k) * `PATARM_MASK_STRIDE) begin
          m = be_merge({16'h0000, io_mask_q[k]}, AVS_WRITEDATA, AVS_BYTEENABLE);
          io_mask_q[k] <= m[15:0];
        end
      end
    end
  end

  // software arm: a write pulse, no enable of its own
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sw_arm_q <= 1'b0;
    end else begin
      sw_arm_q <= wr_fire && AVS_ADDRESS == `PATARM_OFS_SWARM
                  && AVS_BYTEENABLE[0] && AVS_WRITEDATA[`PATARM_SWARM_BIT];
    end
  end

  // -----------------------------------------------------------------------
  // arm timer: period_q + 1 cycles between single-cycle ticks
  // -----------------------------------------------------------------------
  // counter held at zero while disabled so the first tick is a full period late
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      count_q <= `PATARM_COUNT_ZERO;
      tick_q  <= 1'b0;
    end else if (!(timer_en_q && mode_q)) begin
      count_q <= `PATARM_COUNT_ZERO;
      tick_q  <= 1'b0;
    end else if (count_q >= period_q) begin
      count_q <= `PATARM_COUNT_ZERO;
      tick_q  <= 1'b1;
    end else begin
      count_q <= count_q + `PATARM_COUNT_ONE;
      tick_q  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // line sampling and condition match
  // -----------------------------------------------------------------------
  // output lines read back their own drive, input lines follow the scope
  assign bus_raw = (dir_q & INT_BUS_OUT)
                 | (~dir_q & scope_q & EXT_BUS_IN)
                 | (~dir_q & ~scope_q & INT_BUS_IN);

  patarm_line_qual #(.W(8)) u_bus_qual (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .raw_in    (bus_raw),
    .mask_rise (bus_mask_q[0]),
    .mask_fall (bus_mask_q[1]),
    .mask_high (bus_mask_q[2]),
    .mask_low  (bus_mask_q[3]),
    .level     (bus_level),
    .rise      (bus_rise),
    .all_ok    (bus_ok),
    .any_cfg   (bus_cfg)
  );

  patarm_line_qual #(.W(16)) u_io_qual (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .raw_in    (DIGITAL_IO_IN),
    .mask_rise (io_mask_q[0]),
    .mask_fall (io_mask_q[1]),
    .mask_high (io_mask_q[2]),
    .mask_low  (io_mask_q[3]),
    .level     (io_level),
    .rise      (),
    .all_ok    (io_ok),
    .any_cfg   (io_cfg)
  );

  // combined event: every configured source at once, software arm alone
  // is enough; nothing configured means no pattern event at all
  assign event_d = mode_q && (sw_arm_q
                   || ((bus_cfg || io_cfg || timer_en_q)
                       && bus_ok && io_ok && (!timer_en_q || tick_q)));

  // -----------------------------------------------------------------------
  // trigger-bus drive
  // -----------------------------------------------------------------------
  assign out_hot = line_hot(out_sel_q);
  assign drive_v = ((out_state_q & ~out_hot) | ({8{event_d}} & out_hot)) & dir_q;

  // internal bus always carries output lines, external only in wide scope
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      INT_BUS_OUT   <= `PATARM_RST_BYTE;
      INT_BUS_DRIVE <= `PATARM_RST_BYTE;
      EXT_BUS_OUT   <= `PATARM_RST_BYTE;
      EXT_BUS_OE_N  <= ~`PATARM_RST_BYTE;
    end else begin
      INT_BUS_OUT   <= drive_v;
      INT_BUS_DRIVE <= dir_q;
      EXT_BUS_OUT   <= drive_v & scope_q;
      EXT_BUS_OE_N  <= ~(dir_q & scope_q);
    end
  end

  // own arm comes from a rising edge on the selected bus line, read back from its drive if an output
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ARM_EVENT <= 1'b0;
      ARM_OUT   <= 1'b0;
    end else begin
      ARM_EVENT <= event_d;
      ARM_OUT   <= mode_q && bus_rise[in_sel_q];
    end
  end

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_tick;
    tick_q;
  endsequence

  property p_out_state;
    ##1 (INT_BUS_OUT & ~$past(out_hot)) == $past(out_state_q & dir_q & ~out_hot);
  endproperty
  a_out_state: assert property (p_out_state) else $error("output state not on line");

  property p_input_ignored;
    ##1 ((INT_BUS_OUT | EXT_BUS_OUT) & ~$past(dir_q)) == 8'h00;
  endproperty
  a_input_ignored: assert property (p_input_ignored) else $error("input line driven");

  property p_ext_scope;
    ##1 EXT_BUS_OE_N == ~$past(dir_q & scope_q) && INT_BUS_DRIVE == $past(dir_q);
  endproperty
  a_ext_scope: assert property (p_ext_scope) else $error("bus enable wrong for scope");

  property p_sw_arm;
    (sw_arm_q && mode_q) |=> ARM_EVENT;
  endproperty
  a_sw_arm: assert property (p_sw_arm) else $error("software arm lost");

  property p_event_cause;
    ARM_EVENT |-> $past(mode_q) && ($past(sw_arm_q) || ($past(bus_ok) && $past(io_ok)));
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("arm event without cause");

  property p_timer_gate;
    s_tick |-> $past(timer_en_q) && $past(mode_q);
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer tick while disabled");

  // a zero period legally ticks every cycle, and a disable clears the count
  property p_tick_single;
    s_tick && timer_en_q && mode_q && period_q != `PATARM_COUNT_ZERO
      |=> !tick_q && count_q == `PATARM_COUNT_ONE;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("timer pulse not single");

  property p_event_line;
    ARM_EVENT && $past(dir_q[out_sel_q]) && $stable(out_sel_q) |-> INT_BUS_OUT[out_sel_q];
  endproperty
  a_event_line: assert property (p_event_line) else $error("event missing on line");

  property p_arm_in;
    ARM_OUT |-> $past(bus_rise[in_sel_q]) && $past(mode_q);
  endproperty
  a_arm_in: assert property (p_arm_in) else $error("own arm without input edge");

  property p_rise_pulse;
    bus_rise[0] |=> !bus_rise[0];
  endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("edge pulse too long");
endmodule
`default_nettype wire

// ==== verif/patarm_far_model.sv ====
// far side of the trigger bus: other instruments sharing each line
`timescale 1ns/1ps
`default_nettype none
module patarm_far_model (
  input  wire logic [7:0] ext_req,
  input  wire logic [7:0] int_req,
  input  wire logic [7:0] ext_out,
  input  wire logic [7:0] ext_oe_n,
  input  wire logic [7:0] int_out,
  input  wire logic [7:0] int_drive,
  output logic      [7:0] ext_bus,
  output logic      [7:0] int_bus
);
  // a line the device drives shows its value, the rest the far instruments'
  assign ext_bus = (ext_out & ~ext_oe_n) | (ext_req & ext_oe_n);
  assign int_bus = (int_out & int_drive) | (int_req & ~int_drive);
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the pattern arm block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [7:0]  ext_q = 8'h00;
  logic [7:0]  int_q = 8'h00;
  logic [15:0] io_q = 16'h0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        wait_rq;
  logic        arm_ev;
  logic        arm_o;
  logic [7:0]  ext_o, ext_oe_n, int_o, int_dr, ext_b, int_b;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h30, 8'h3c};
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n_ev, n_ao, n_ln, w_ev, w_ao, w_ln;

  // --------------------------------------------------------------
  // clock, design and far side
  // --------------------------------------------------------------
  always #4 clk = ~clk;

  patarm_top patarm_top_i (
    .CLOCK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq), .EXT_BUS_IN(ext_b),
    .EXT_BUS_OUT(ext_o), .EXT_BUS_OE_N(ext_oe_n), .INT_BUS_IN(int_b),
    .INT_BUS_OUT(int_o), .INT_BUS_DRIVE(int_dr), .DIGITAL_IO_IN(io_q),
    .ARM_EVENT(arm_ev), .ARM_OUT(arm_o));

  patarm_far_model patarm_far_model_i (
    .ext_req(ext_q), .int_req(int_q), .ext_out(ext_o), .ext_oe_n(ext_oe_n),
    .int_out(int_o), .int_drive(int_dr), .ext_bus(ext_b), .int_bus(int_b));

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pulse counts are judged against a range, exact where lo equals hi
  task automatic chk_n(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // one avalon transfer; held until waitrequest is sampled low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    do @(posedge clk); while (wait_rq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic set_ln(input int g, input logic v);
    if (g == 0) int_q[2] <= v;
    else io_q[3] <= v;
  endtask

  // counts cleared off the edge so no race with the counting process
  task automatic win(input int n);
    @(negedge clk);
    n_ev = 0;
    n_ao = 0;
    n_ln = 0;
    repeat (n) @(posedge clk);
    @(negedge clk);
    w_ev = n_ev;
    w_ao = n_ao;
    w_ln = n_ln;
    @(posedge clk);
  endtask

  // pulse counters and the hang limit
  always @(posedge clk) begin
    cyc++;
    if (arm_ev === 1'b1) n_ev++;
    if (arm_o === 1'b1) n_ao++;
    if (int_o[4] === 1'b1 && ext_o[4] === 1'b1 && ext_oe_n[4] === 1'b0) n_ln++;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("oe_n", 32'hff, 32'(ext_oe_n));
    chk("drive", 32'h0, 32'(int_dr));
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset", ra[i], (ra[i] == 8'h30) ? 32'h7cf : 32'h0);
    end
    av(1'b1, 8'h10, 32'hffff_ffff);
    av(1'b1, 8'h20, 32'hffff_ffff);
    av(1'b1, 8'h3c, 32'hffff_ffff);
    rd_chk("bus mask", 8'h10, 32'h0000_00ff);
    rd_chk("io mask", 8'h20, 32'h0000_ffff);
    rd_chk("unmapped", 8'h3c, 32'h0);
    av(1'b1, 8'h10, 32'h0);
    av(1'b1, 8'h20, 32'h0);
    // output state and line routing; event line parked on an input line
    av(1'b1, 8'h00, 32'h70);
    av(1'b1, 8'h04, 32'h0f);
    av(1'b1, 8'h08, 32'h25);
    av(1'b1, 8'h0c, 32'h81);
    int_q <= 8'h50;
    ext_q <= 8'ha0;
    io_q <= 16'ha5c3;
    repeat (4) @(posedge clk);
    rd_chk("outstate", 8'h0c, 32'h81);
    chk("int drive", 32'h0f, 32'(int_dr));
    chk("int out", 32'h01, 32'(int_o & 8'h0f));
    chk("ext oe_n", 32'hfa, 32'(ext_oe_n));
    chk("ext out", 32'h01, 32'(ext_o & 8'h05));
    rd_chk("status", 8'h38, 32'h00a5_c371);
    // one mask at a time on bus line 2 and io line 3
    int_q <= 8'h00;
    ext_q <= 8'h00;
    io_q <= 16'h0;
    av(1'b1, 8'h08, 32'h10);
    av(1'b1, 8'h04, 32'h10);
    av(1'b1, 8'h00, 32'h0441);
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 4; k++) begin
        set_ln(g, k[0]);
        av(1'b1, (g == 1 ? 8'h20 : 8'h10) + 8'(4 * k), g == 1 ? 32'h8 : 32'h4);
        repeat (6) @(posedge clk);
        win(10);
        chk_n("quiet", 0, 0, w_ev);
        set_ln(g, ~k[0]);
        // an edge gives one pulse; a level fires from the fourth edge on
        win(8);
        chk_n("change", k[1] ? 5 : 1, k[1] ? 5 : 1, w_ev);
        win(10);
        chk_n("steady", k[1] ? 10 : 0, k[1] ? 10 : 0, w_ev);
        av(1'b1, (g == 1 ? 8'h20 : 8'h10) + 8'(4 * k), 32'h0);
      end
    end
    // two sources by AND, two conditions on one line by OR
    av(1'b1, 8'h18, 32'h4);
    av(1'b1, 8'h28, 32'h8);
    int_q <= 8'h04;
    io_q <= 16'h0;
    repeat (6) @(posedge clk);
    win(10);
    chk_n("and one", 0, 0, w_ev);
    io_q <= 16'h0008;
    repeat (6) @(posedge clk);
    win(10);
    chk_n("and both", 10, 10, w_ev);
    av(1'b1, 8'h28, 32'h0);
    av(1'b1, 8'h1c, 32'h4);
    int_q <= 8'h00;
    repeat (6) @(posedge clk);
    win(10);
    chk_n("or", 10, 10, w_ev);
    av(1'b1, 8'h18, 32'h0);
    av(1'b1, 8'h1c, 32'h0);
    // software arm, with and without pattern mode
    repeat (6) @(posedge clk);
    av(1'b1, 8'h34, 32'h1);
    win(12);
    chk_n("sw arm", 1, 1, w_ev);
    chk_n("sw line", 1, 1, w_ln);
    chk_n("sw own", 1, 1, w_ao);
    rd_chk("sw read", 8'h34, 32'h0);
    av(1'b1, 8'h00, 32'h0440);
    av(1'b1, 8'h34, 32'h1);
    win(12);
    chk_n("sw off", 0, 0, w_ev);
    // short timer period: one tick every four cycles
    av(1'b1, 8'h30, 32'h3);
    av(1'b1, 8'h00, 32'h0443);
    repeat (10) @(posedge clk);
    win(40);
    chk_n("timer", 10, 10, w_ev);
    chk_n("out line", 10, 10, w_ln);
    chk_n("own arm", 10, 10, w_ao);
    av(1'b1, 8'h00, 32'h0641);
    int_q <= 8'h40;
    win(10);
    chk_n("timer off", 0, 0, w_ev);
    chk_n("own arm in", 1, 1, w_ao);
    give_verdict();
  end
endmodule
`default_nettype wire
